/* pkg/hms_pkg.sv */
// Constants and carrier types for the hardware monitor cycle sequencer
// Behaviour
// - each voltage channel has high/low limits; out-of-range stored value raises request
// - temperature has hot limit and lower hysteresis limit; alarm sets above, releases at or below
// - writing start=1 with interrupt-clear=0 begins the measurement cycle
// - active-low interrupt output driven only while interrupt-enable is one
// - sequence starts at core_rail_b_input and ends with the temperature sensor
// - each finished conversion is stored into its channel value register automatically
// - sequence repeats until software writes zero to the start field
// - channel counter advances at nominal 22.5 kHz; seven slots of 44.4 us
// - fan monitoring starts together with the analog cycle, then runs unsynchronised
// - analog output follows an unsigned 8-bit code, zero minimum, full maximum
// - reset loads the analog-output code with all ones
// - temperature result is 9-bit two's complement; upper eight bits are compared
package hms_pkg;
  localparam int          HMS_NUM_CH       = 7;
  localparam int          HMS_NUM_VOLT     = 6;
  localparam int          HMS_TEMP_CH      = 6;
  localparam int          HMS_CLK_HZ       = 100_000_000;
  localparam int          HMS_SLOT_RATE_HZ = 22_500;
  localparam int          HMS_SLOT_CYC     = HMS_CLK_HZ / HMS_SLOT_RATE_HZ;
  localparam int          HMS_CFG_START    = 0;
  localparam int          HMS_CFG_INT_EN   = 1;
  localparam int          HMS_CFG_INT_CLR  = 3;
  localparam logic [7:0]  HMS_AOUT_RST     = 8'hff;
  localparam logic [7:0]  HMS_CFG_RST      = 8'h00;
  localparam logic [7:0]  HMS_LIM_HI_RST   = 8'hff;
  localparam logic [7:0]  HMS_LIM_LO_RST   = 8'h00;
  localparam logic [7:0]  HMS_HOT_RST      = 8'h7f;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } hms_limit_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
    logic [8:0] data;
  } hms_result_t;
endpackage : hms_pkg

/* logic/hms_sequencer.sv */
// Round-robin conversion sequencer with limit checking and analog-output register
`timescale 1ns/1ps
`default_nettype none
module hms_sequencer
  import hms_pkg::*;
#(
  parameter int SLOT_CYC = HMS_SLOT_CYC
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      clk_en_i,
  input  wire logic                      cfg_wr_i,
  input  wire logic [7:0]                cfg_wdata_i,
  input  wire hms_limit_t [HMS_NUM_VOLT-1:0] volt_lim_i,
  input  wire logic [7:0]                hot_lim_i,
  input  wire logic [7:0]                hot_hyst_i,
  input  wire logic                      aout_wr_i,
  input  wire logic [7:0]                aout_wdata_i,
  input  wire hms_result_t               conv_i,
  output logic                           conv_start_o,
  output logic [2:0]                     mux_sel_o,
  output logic                           fan_start_o,
  output logic                           running_o,
  output logic [7:0]                     cfg_o,
  output logic [8:0]                     value_o [HMS_NUM_CH],
  output logic [HMS_NUM_VOLT-1:0]        volt_alarm_o,
  output logic                           temp_alarm_o,
  output logic                           irq_req_o,
  output logic                           int_n_o,
  output logic                           int_n_oe_o,
  output logic [7:0]                     aout_code_o
);

  logic [7:0]                cfg_r;
  logic                      run_r;
  logic [15:0]               slot_cnt_r;
  logic [2:0]                chan_r;
  logic                      conv_start_r;
  logic                      fan_start_r;
  logic [8:0]                value_r [HMS_NUM_CH];
  logic [HMS_NUM_VOLT-1:0]   volt_alarm_r;
  logic                      temp_alarm_r;
  logic [7:0]                aout_r;
  logic                      start_cmd;
  logic                      stop_cmd;
  logic                      slot_end;
  logic                      last_chan;
  logic                      slot_next;
  logic                      res_take;
  logic [HMS_NUM_CH-1:0]     res_hit;
  logic [HMS_NUM_VOLT-1:0]   volt_above;
  logic [HMS_NUM_VOLT-1:0]   volt_below;
  logic signed [7:0]         temp_top;
  logic                      temp_hot;
  logic                      temp_cool;
  logic                      irq_any;

  // A write with both start and interrupt-clear set only updates the configuration
  assign start_cmd = cfg_wr_i && cfg_wdata_i[HMS_CFG_START] && !cfg_wdata_i[HMS_CFG_INT_CLR];
  assign stop_cmd  = cfg_wr_i && !cfg_wdata_i[HMS_CFG_START];
  assign slot_end  = (slot_cnt_r == 16'(SLOT_CYC - 1));
  assign last_chan = (chan_r == 3'(HMS_NUM_CH - 1));
  // Stop outranks the slot boundary, so no conversion is launched on the stop cycle
  assign slot_next = run_r && slot_end && !stop_cmd;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= HMS_CFG_RST;
    end else if (clk_en_i && cfg_wr_i) begin
      cfg_r <= cfg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
    end else if (clk_en_i) begin
      if (start_cmd) begin
        run_r <= 1'b1;
      end else if (stop_cmd) begin
        run_r <= 1'b0;
      end
    end
  end

  // Sixteen bits cover the default slot; a much slower slot rate needs a wider counter
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      slot_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (start_cmd || stop_cmd || slot_next) begin
        slot_cnt_r <= '0;
      end else if (run_r) begin
        slot_cnt_r <= slot_cnt_r + 16'h1;
      end
    end
  end

  // A start while running restarts the sequence at the first channel
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      chan_r <= '0;
    end else if (clk_en_i) begin
      if (start_cmd) begin
        chan_r <= '0;
      end else if (slot_next) begin
        chan_r <= last_chan ? 3'h0 : chan_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      conv_start_r <= 1'b0;
    end else if (clk_en_i) begin
      conv_start_r <= start_cmd || slot_next;
    end
  end

  // Fan timing is only kicked off here; it then runs on its own
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fan_start_r <= 1'b0;
    end else if (clk_en_i) begin
      fan_start_r <= start_cmd;
    end
  end

  // Results land only while running and only for a real channel
  assign res_take  = clk_en_i && run_r && conv_i.valid;
  assign temp_top  = $signed(conv_i.data[8:1]);
  assign temp_hot  = (temp_top > $signed(hot_lim_i));
  assign temp_cool = (temp_top <= $signed(hot_hyst_i));

  genvar g;
  generate
    for (g = 0; g < HMS_NUM_CH; g++) begin : g_val
      assign res_hit[g] = res_take && (conv_i.chan == 3'(g));
      // Stored words keep all nine bits on every channel; voltage limits compare only the low eight
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          value_r[g] <= '0;
        end else if (res_hit[g]) begin
          value_r[g] <= conv_i.data;
        end
      end
    end
    for (g = 0; g < HMS_NUM_VOLT; g++) begin : g_volt
      assign volt_above[g] = (conv_i.data[7:0] > volt_lim_i[g].hi);
      assign volt_below[g] = (conv_i.data[7:0] < volt_lim_i[g].lo);
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          volt_alarm_r[g] <= 1'b0;
        end else if (res_hit[g]) begin
          volt_alarm_r[g] <= volt_above[g] || volt_below[g];
        end
      end
    end
  endgenerate

  // Between the two temperature limits the alarm holds its last state
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      temp_alarm_r <= 1'b0;
    end else if (res_hit[HMS_TEMP_CH]) begin
      if (temp_hot) begin
        temp_alarm_r <= 1'b1;
      end else if (temp_cool) begin
        temp_alarm_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aout_r <= HMS_AOUT_RST;
    end else if (clk_en_i && aout_wr_i) begin
      aout_r <= aout_wdata_i;
    end
  end

  // Interrupt-clear masks the pin without losing the alarm state
  assign irq_any    = (|volt_alarm_r) || temp_alarm_r;
  assign irq_req_o  = irq_any && !cfg_r[HMS_CFG_INT_CLR];
  assign int_n_oe_o = cfg_r[HMS_CFG_INT_EN] && irq_req_o;
  assign int_n_o    = 1'b0;

  assign conv_start_o = conv_start_r;
  assign mux_sel_o    = chan_r;
  assign fan_start_o  = fan_start_r;
  assign running_o    = run_r;
  assign cfg_o        = cfg_r;
  assign value_o      = value_r;
  assign volt_alarm_o = volt_alarm_r;
  assign temp_alarm_o = temp_alarm_r;
  assign aout_code_o  = aout_r;

endmodule : hms_sequencer
`default_nettype wire

/* dv/hms_sequencer_asserts.sv */
// Port checker for the cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module hms_sequencer_asserts import hms_pkg::*; #(parameter int SLOT_CYC = 8) (
  input wire logic clk_sys_i, rst_i, clk_en_i, cfg_wr_i, conv_start_o, fan_start_o, running_o,
  input wire logic temp_alarm_o, irq_req_o, int_n_oe_o, input wire logic [2:0] mux_sel_o,
  input wire logic [7:0] cfg_wdata_i, hot_lim_i, hot_hyst_i, cfg_o, input wire logic [5:0] volt_alarm_o,
  input wire hms_limit_t [5:0] volt_lim_i, input wire hms_result_t conv_i);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_go; clk_en_i && cfg_wr_i && cfg_wdata_i[0] && !cfg_wdata_i[3]; endsequence
  sequence s_res(int ch); clk_en_i && running_o && !cfg_wr_i && conv_i.valid && conv_i.chan == ch; endsequence
  cycle_start_a: assert property (s_go |=> running_o && conv_start_o && fan_start_o && !mux_sel_o)
    else $error("no start");
  cycle_stop_a: assert property (clk_en_i && cfg_wr_i && !cfg_wdata_i[0] |=> !running_o ##1 !conv_start_o [*4])
    else $error("no stop");
  fan_with_a: assert property (fan_start_o |-> conv_start_o && mux_sel_o == 3'h0)
    else $error("fan start");
  int_pin_a: assert property (int_n_oe_o == (cfg_o[1] && irq_req_o))
    else $error("pin enable");
  irq_source_a: assert property (irq_req_o == ((|volt_alarm_o || temp_alarm_o) && !cfg_o[3]))
    else $error("request");
  volt_high_a: assert property (s_res(2) ##0 conv_i.data[7:0] > volt_lim_i[2].hi |=> volt_alarm_o[2])
    else $error("volt");
  volt_low_a: assert property (s_res(2) ##0 conv_i.data[7:0] < volt_lim_i[2].lo |=> volt_alarm_o[2])
    else $error("volt low");
  temp_hot_a: assert property (s_res(6) ##0 $signed(conv_i.data[8:1]) > $signed(hot_lim_i) |=> temp_alarm_o)
    else $error("hot");
  temp_cool_a: assert property (s_res(6) ##0 $signed(conv_i.data[8:1]) <= $signed(hot_hyst_i) |=> !temp_alarm_o)
    else $error("cool");
endmodule : hms_sequencer_asserts
bind hms_sequencer hms_sequencer_asserts #(.SLOT_CYC(SLOT_CYC)) chk_u (.*);
`default_nettype wire

/* dv/hms_conv_model.sv */
// Converter model answering each slot start after dly_i cycles
`timescale 1ns/1ps
`default_nettype none
module hms_conv_model import hms_pkg::*; (input wire logic clk_i, rst_i, start_i, input wire logic [2:0] sel_i,
  input wire logic [3:0] dly_i, input wire logic [8:0] level_i [7], output hms_result_t res_o);
  logic [3:0] cnt_r;
  logic [2:0] ch_r;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) {cnt_r, ch_r, res_o} <= '0;
    else begin
      // Data inverted outside valid so a stale sample never matches
      res_o <= {cnt_r == 4'h1, ch_r, (cnt_r == 4'h1) ? level_i[ch_r] : ~level_i[ch_r]};
      if (start_i) {cnt_r, ch_r} <= {dly_i, sel_i};
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
endmodule : hms_conv_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hms_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, clk_en_i = 1, cfg_wr_i = 0, aout_wr_i = 0, conv_start_o, fan_start_o;
  logic running_o, temp_alarm_o, irq_req_o, int_n_o, int_n_oe_o;
  logic [7:0] cfg_wdata_i = '0, aout_wdata_i = '0, cfg_o, aout_code_o, hot_lim_i = 8'h50, hot_hyst_i = 8'h40;
  logic [2:0] mux_sel_o;
  logic [3:0] dly = 4'h1;
  logic [5:0] volt_alarm_o;
  logic [8:0] value_o [7], lvl [7] = '{9'h050, 9'h060, 9'h090, 9'h070, 9'h041, 9'h07f, 9'h0f0};
  hms_limit_t [5:0] volt_lim_i = {6{16'h8040}};
  hms_result_t conv_i;
  int num_errors = 0, samples_checked = 0;
  hms_sequencer #(.SLOT_CYC(8)) dut_u (.*);
  hms_conv_model conv_u (.clk_i(clk_sys_i), .rst_i, .start_i(conv_start_o), .sel_i(mux_sel_o), .dly_i(dly),
    .level_i(lvl), .res_o(conv_i));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [8:0] s, e, input string n);
    samples_checked++;
    if (s !== e) begin num_errors++; $display("Error %s expected %h seen %h", n, e, s); end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] d, input logic a);
    cyc(1);
    {cfg_wdata_i, aout_wdata_i, cfg_wr_i, aout_wr_i} = {d, d, !a, a};
    cyc(1);
    {cfg_wr_i, aout_wr_i} = 2'b00;
  endtask : wr
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic t_seq;
    int c;
    chk(aout_code_o, 9'h0ff, "aout reset");
    wr(8'h5a, 1);
    chk(aout_code_o, 9'h05a, "aout");
    wr(8'h03, 0);
    chk(fan_start_o, 1, "fan");
    for (int k = 0; k < 8; k++) begin
      chk(mux_sel_o, k % 7, "mux");
      dly = (k > 3) ? 4'h6 : 4'h1;
      for (c = 1; c < 50; c++) begin cyc(1); if (conv_start_o === 1'b1) break; end
      chk(c, 8, "slot");
      if (c == 50) conclude();
    end
    for (int k = 0; k < 7; k++) chk(value_o[k], lvl[k], "value");
    chk({volt_alarm_o, temp_alarm_o, int_n_oe_o, int_n_o}, 9'h026, "alarms");
  endtask : t_seq
  task automatic t_cool;
    lvl[2] = 9'h03f;
    lvl[6] = 9'h060;
    cyc(56);
    chk({volt_alarm_o, temp_alarm_o}, 9'h008, "cool");
  endtask : t_cool
  task automatic t_stop;
    wr(8'h00, 0);
    repeat (16) begin cyc(1); chk({running_o, conv_start_o}, 0, "stop"); end
    wr(8'h0b, 0);
    chk({running_o, int_n_oe_o}, 0, "clear");
    chk(cfg_o, 9'h00b, "cfg");
    wr(8'h01, 0);
    chk({running_o, irq_req_o, int_n_oe_o}, 9'h006, "no enable");
  endtask : t_stop
  // Clock enable low must freeze everything, then a mid-run reset restores defaults
  task automatic t_freeze;
    {clk_en_i, aout_wr_i, aout_wdata_i} = {2'b01, 8'h33};
    cyc(20);
    chk(aout_code_o, 9'h05a, "freeze aout");
    chk(mux_sel_o, 0, "freeze mux");
    {clk_en_i, aout_wr_i} = 2'b10;
    cyc(9);
    chk(mux_sel_o, 1, "thaw mux");
    rst_i = 1;
    cyc(2);
    chk({aout_code_o, running_o}, 9'h1fe, "reset");
    rst_i = 0;
    cyc(2);
  endtask : t_freeze
  initial begin
    cyc(10);
    rst_i = 0;
    t_seq();
    t_cool();
    t_stop();
    t_freeze();
    conclude();
  end
endmodule : testbench
`default_nettype wire
